// *** hw/stack_command_handler.sv ***
// command execution logic of one stack device
// Functional notes
// R01: scan inhibit clears continuous-scan flag
// R02: addressed measure runs one stored conversion
// R03: selector from length; 0 pack, 1-14 cells
// R04: temps, gpios, reference map; some reserved
// R05: host reads result separately after measure
// R06: mux test command runs routing diagnostic
// R07: balance enable sets run flag only
// R08: balance inhibit clears run flag only
// R09: host issues enumeration after resets
// R10: top answers enumeration with own address
// R11: lower port traffic ends enumeration mode
// R12: enumeration any address; bad crc ignored
// R13: top when address equals stack size
// R14: no valid reply above means act top
// R15: master naks enumeration crc error
// R16: eight acknowledge clocks, fewer discarded
// R17: relay enumeration response despite errors
// R18: nak commands that cannot execute
// R19: ack command, top, and writes answer ack
// R20: ack failure nak carries stack position; code sends no nak, its timeout reply carries own_addr
// R21: timeout waiting above sends comms failure
// R22: sleep command enters sleep mode
// R23: continuous scan sets the scan flag
// R24: reserved selector naks, no conversion
`timescale 1ns/1ps
module stack_command_handler #(
   parameter int TIMEOUT_CYCLES = stack_cmd_pkg::TIMEOUT_CYC
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic is_master,
   input wire logic [4:0] own_addr,
   input wire logic [4:0] stack_size,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic [5:0] cmd_len,
   input wire logic addr_match,
   input wire logic crc_ok,
   input wire logic reg_ok,
   input wire logic is_write,
   input wire logic lower_traffic,
   input wire logic up_rsp_valid,
   input wire logic up_ack_clk,
   input wire logic conv_done,
   input wire logic mux_done,
   output logic scan_cont_q,
   output logic balance_run_flag_q,
   output logic sleep_q,
   output logic enum_mode_q,
   output logic is_top_q,
   output logic conv_start_q,
   output logic [5:0] conv_sel_q,
   output logic mux_test_q,
   output logic relay_up_q,
   output logic relay_down_q,
   output logic rsp_valid_q,
   output logic [7:0] rsp_code_q,
   output logic [4:0] rsp_pos_q
);
   ////////////////////////////////////////////////////////////////
   stack_cmd_pkg::state_e state_q;
   logic [31:0] tmr_q;
   logic wait_enum_q;
   logic [5:0] sel;
   logic sel_bad;
   logic exec;
   ack_clk_if ack_link ();
   assign sel = cmd_len;
   assign exec = cmd_valid && crc_ok && state_q == stack_cmd_pkg::ST_IDLE;
   // reserved or out of range selectors
   assign sel_bad = sel == stack_cmd_pkg::SEL_RSVD_A
      || sel == stack_cmd_pkg::SEL_RSVD_B
      || sel == stack_cmd_pkg::SEL_RSVD_C
      || sel > stack_cmd_pkg::SEL_REF; // see R24
   assign ack_link.start = exec && cmd_code == stack_cmd_pkg::CMD_ENUMERATE;
   assign ack_link.clk_edge = up_ack_clk;

   ack_clk_counter u_ack (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .link(ack_link)
   );

   ////////////////////////////////////////////////////////////////
   // scan, balance and sleep flags
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         scan_cont_q <= 1'b0;
         balance_run_flag_q <= 1'b0;
         sleep_q <= 1'b0;
      end else if (exec && addr_match) begin
         case (cmd_code)
            stack_cmd_pkg::CMD_SCAN_CONT: scan_cont_q <= 1'b1; // see R23
            stack_cmd_pkg::CMD_SCAN_INHIBIT: scan_cont_q <= 1'b0; // see R01
            stack_cmd_pkg::CMD_BAL_ENABLE: balance_run_flag_q <= 1'b1; // see R07
            stack_cmd_pkg::CMD_BAL_INHIBIT: balance_run_flag_q <= 1'b0; // see R08
            stack_cmd_pkg::CMD_SLEEP: sleep_q <= 1'b1; // see R22
            default: sleep_q <= sleep_q;
         endcase
      end else if (lower_traffic && cmd_valid) begin
         sleep_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // enumeration mode and top detection
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         enum_mode_q <= 1'b0;
         is_top_q <= 1'b0;
      end else begin
         is_top_q <= own_addr == stack_size; // see R13
         if (ack_link.start) begin
            enum_mode_q <= 1'b1; // see R12
         end else if (lower_traffic) begin
            enum_mode_q <= 1'b0; // see R11
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // command sequencer
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= stack_cmd_pkg::ST_IDLE;
         tmr_q <= 32'h0;
         wait_enum_q <= 1'b0;
         conv_start_q <= 1'b0;
         conv_sel_q <= 6'h00;
         mux_test_q <= 1'b0;
         relay_up_q <= 1'b0;
         relay_down_q <= 1'b0;
         rsp_valid_q <= 1'b0;
         rsp_code_q <= 8'h00;
         rsp_pos_q <= stack_cmd_pkg::STACK_POS_RESET;
      end else begin
         conv_start_q <= 1'b0;
         relay_up_q <= 1'b0;
         relay_down_q <= 1'b0;
         rsp_valid_q <= 1'b0;
         case (state_q)
            stack_cmd_pkg::ST_IDLE: begin
               if (cmd_valid && !crc_ok) begin
                  // enumeration crc error: only master answers
                  if (cmd_code != stack_cmd_pkg::CMD_ENUMERATE
                      || is_master) begin
                     rsp_valid_q <= 1'b1; // see R15
                     rsp_code_q <= stack_cmd_pkg::CMD_NAK; // see R18
                     rsp_pos_q <= own_addr;
                  end
               end else if (exec) begin
                  case (cmd_code)
                     stack_cmd_pkg::CMD_ENUMERATE: begin
                        if (is_top_q) begin
                           rsp_valid_q <= 1'b1; // see R10
                           rsp_code_q <= stack_cmd_pkg::CMD_ENUMERATE;
                           rsp_pos_q <= own_addr;
                        end else begin
                           relay_up_q <= 1'b1;
                           wait_enum_q <= 1'b1;
                           tmr_q <= 32'h0;
                           state_q <= stack_cmd_pkg::ST_WAIT_UP;
                        end
                     end
                     stack_cmd_pkg::CMD_MEASURE: begin
                        if (!addr_match) begin
                           state_q <= stack_cmd_pkg::ST_IDLE;
                        end else if (sel_bad) begin
                           rsp_valid_q <= 1'b1; // see R24
                           rsp_code_q <= stack_cmd_pkg::CMD_NAK;
                           rsp_pos_q <= own_addr;
                        end else begin
                           conv_start_q <= 1'b1; // see R02
                           conv_sel_q <= sel; // see R03, R04
                           state_q <= stack_cmd_pkg::ST_MEASURE;
                        end
                     end
                     stack_cmd_pkg::CMD_MUX_TEST: begin
                        if (addr_match) begin
                           mux_test_q <= 1'b1; // see R06
                           state_q <= stack_cmd_pkg::ST_MUXTEST;
                        end
                     end
                     stack_cmd_pkg::CMD_ACK: begin
                        if (addr_match || is_top_q) begin
                           rsp_valid_q <= 1'b1; // see R19
                           rsp_code_q <= stack_cmd_pkg::CMD_ACK;
                           rsp_pos_q <= own_addr;
                        end else begin
                           relay_up_q <= 1'b1;
                           wait_enum_q <= 1'b0;
                           tmr_q <= 32'h0;
                           state_q <= stack_cmd_pkg::ST_WAIT_UP;
                        end
                     end
                     default: begin
                        if (addr_match && !reg_ok) begin
                           rsp_valid_q <= 1'b1; // see R18
                           rsp_code_q <= stack_cmd_pkg::CMD_NAK;
                           rsp_pos_q <= own_addr;
                        end else if (addr_match && is_write) begin
                           rsp_valid_q <= 1'b1; // see R19
                           rsp_code_q <= stack_cmd_pkg::CMD_ACK;
                           rsp_pos_q <= own_addr;
                        end
                     end
                  endcase
               end
            end
            stack_cmd_pkg::ST_WAIT_UP: begin
               tmr_q <= tmr_q + 32'h1;
               if (wait_enum_q && ack_link.good) begin
                  // acknowledged: await the top response
                  wait_enum_q <= 1'b0;
                  tmr_q <= 32'h0;
               end else if (up_rsp_valid && !wait_enum_q) begin
                  relay_down_q <= 1'b1; // see R17
                  state_q <= stack_cmd_pkg::ST_IDLE;
               end else if (tmr_q >= 32'(TIMEOUT_CYCLES - 1)) begin
                  rsp_valid_q <= 1'b1;
                  rsp_pos_q <= own_addr; // see R20
                  state_q <= stack_cmd_pkg::ST_IDLE;
                  if (wait_enum_q) begin
                     rsp_code_q <= stack_cmd_pkg::CMD_ENUMERATE; // see R14
                  end else begin
                     rsp_code_q <= stack_cmd_pkg::CMD_COMMS_FAIL; // see R21
                  end
               end
            end
            stack_cmd_pkg::ST_MEASURE: begin
               if (conv_done) begin
                  state_q <= stack_cmd_pkg::ST_IDLE;
               end
            end
            stack_cmd_pkg::ST_MUXTEST: begin
               if (mux_done) begin
                  mux_test_q <= 1'b0;
                  state_q <= stack_cmd_pkg::ST_IDLE;
               end
            end
            default: state_q <= stack_cmd_pkg::ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   AST_INHIBIT: assert property (@(posedge core_clk) disable iff (!arst_n)
      exec && addr_match && cmd_code == stack_cmd_pkg::CMD_SCAN_INHIBIT
      |=> !scan_cont_q) // see R01
      else $error("scan flag not cleared");
   AST_CONT: assert property (@(posedge core_clk) disable iff (!arst_n)
      exec && addr_match && cmd_code == stack_cmd_pkg::CMD_SCAN_CONT
      |=> scan_cont_q) // see R23
      else $error("scan flag not set");
   AST_MEASURE_ONCE: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      conv_start_q |=> !conv_start_q) // see R02
      else $error("more than one conversion");
   AST_MEASURE_SEL: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      exec && addr_match && cmd_code == stack_cmd_pkg::CMD_MEASURE
      && !sel_bad |=> conv_start_q && conv_sel_q == $past(cmd_len)) // see R03
      else $error("wrong measure selector");
   AST_RSVD_NAK: assert property (@(posedge core_clk) disable iff (!arst_n)
      exec && addr_match && cmd_code == stack_cmd_pkg::CMD_MEASURE
      && sel_bad |=> !conv_start_q && rsp_code_q == stack_cmd_pkg::CMD_NAK)
      // see R24
      else $error("reserved selector not refused");
   AST_BAL_EN: assert property (@(posedge core_clk) disable iff (!arst_n)
      exec && addr_match && cmd_code == stack_cmd_pkg::CMD_BAL_ENABLE
      |=> balance_run_flag_q && $stable(scan_cont_q)) // see R07
      else $error("balance enable wrong");
   AST_BAL_DIS: assert property (@(posedge core_clk) disable iff (!arst_n)
      exec && addr_match && cmd_code == stack_cmd_pkg::CMD_BAL_INHIBIT
      |=> !balance_run_flag_q) // see R08
      else $error("balance inhibit wrong");
   AST_SLEEP: assert property (@(posedge core_clk) disable iff (!arst_n)
      exec && addr_match && cmd_code == stack_cmd_pkg::CMD_SLEEP
      |=> sleep_q) // see R22
      else $error("sleep not entered");
   AST_ENUM_EXIT: assert property (@(posedge core_clk) disable iff (!arst_n)
      lower_traffic && !ack_link.start |=> !enum_mode_q) // see R11
      else $error("enumeration mode kept");
   AST_TOP: assert property (@(posedge core_clk) disable iff (!arst_n)
      ##1 is_top_q == $past(own_addr == stack_size)) // see R13
      else $error("top detection wrong");
   AST_ENUM_CRC: assert property (@(posedge core_clk) disable iff (!arst_n)
      cmd_valid && !crc_ok && cmd_code == stack_cmd_pkg::CMD_ENUMERATE
      && state_q == stack_cmd_pkg::ST_IDLE && !lower_traffic
      |=> $stable(enum_mode_q) && !relay_up_q
      && rsp_valid_q == $past(is_master)) // see R12 R15
      else $error("bad crc enumeration handled");
   AST_CRC_NAK: assert property (@(posedge core_clk) disable iff (!arst_n)
      cmd_valid && !crc_ok && state_q == stack_cmd_pkg::ST_IDLE
      && cmd_code != stack_cmd_pkg::CMD_ENUMERATE
      |=> rsp_valid_q && rsp_code_q == stack_cmd_pkg::CMD_NAK) // see R18
      else $error("bad crc command not refused");
   AST_RELAY_DOWN: assert property (@(posedge core_clk) disable iff (!arst_n)
      state_q == stack_cmd_pkg::ST_WAIT_UP && !wait_enum_q && up_rsp_valid
      |=> relay_down_q) // see R17
      else $error("reply from above not relayed");
   COV_ACK_SHORT: cover property (@(posedge core_clk) ack_link.bad);
   COV_MEASURE: cover property (@(posedge core_clk) conv_start_q);
   COV_TIMEOUT: cover property (@(posedge core_clk)
      rsp_valid_q && rsp_code_q == stack_cmd_pkg::CMD_COMMS_FAIL);
   COV_ENUM_TOP: cover property (@(posedge core_clk)
      rsp_valid_q && rsp_code_q == stack_cmd_pkg::CMD_ENUMERATE);
endmodule

// *** hw/stack_cmd_pkg.sv ***
// constants shared by the stack command handler
package stack_cmd_pkg;
   localparam logic [7:0] CMD_SCAN_CONT = 8'hc6;
   localparam logic [7:0] CMD_SCAN_INHIBIT = 8'hc7;
   localparam logic [7:0] CMD_MEASURE = 8'hc8;
   localparam logic [7:0] CMD_MUX_TEST = 8'hc9;
   localparam logic [7:0] CMD_BAL_ENABLE = 8'hca;
   localparam logic [7:0] CMD_BAL_INHIBIT = 8'hcb;
   localparam logic [7:0] CMD_ENUMERATE = 8'hd0;
   localparam logic [7:0] CMD_NAK = 8'hd1;
   localparam logic [7:0] CMD_ACK = 8'hd2;
   localparam logic [7:0] CMD_COMMS_FAIL = 8'hd3;
   localparam logic [7:0] CMD_SLEEP = 8'hd4;
   localparam logic [5:0] SEL_PACK = 6'h00;
   localparam logic [5:0] SEL_CELL_LAST = 6'h0e;
   localparam logic [5:0] SEL_RSVD_A = 6'h0f;
   localparam logic [5:0] SEL_INT_TEMP = 6'h10;
   localparam logic [5:0] SEL_EXT_LAST = 6'h14;
   localparam logic [5:0] SEL_RSVD_B = 6'h15;
   localparam logic [5:0] SEL_RSVD_C = 6'h16;
   localparam logic [5:0] SEL_GPIO_FIRST = 6'h17;
   localparam logic [5:0] SEL_REF = 6'h19;
   localparam logic [3:0] ENUM_ACK_CLOCKS = 4'h8;
   localparam int TIMEOUT_US = 100;
   localparam int CLK_MHZ = 100;
   localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
   localparam logic [4:0] STACK_POS_RESET = 5'h00;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WAIT_UP = 3'b001,
      ST_REPLY = 3'b011,
      ST_MEASURE = 3'b010,
      ST_MUXTEST = 3'b110
   } state_e;
   typedef enum logic [2:0] {
      RSP_NONE = 3'h0,
      RSP_ACK = 3'h1,
      RSP_NAK = 3'h2,
      RSP_FAIL = 3'h3,
      RSP_ENUM = 3'h4
   } rsp_e;
endpackage

// *** hw/ack_clk_if.sv ***
// link between handler and the enumeration acknowledge counter
`timescale 1ns/1ps
interface ack_clk_if;
   logic start;
   logic clk_edge;
   logic good;
   logic bad;
   modport ctl (output start, output clk_edge, input good, input bad);
   modport cnt (input start, input clk_edge, output good, output bad);
endinterface

// *** hw/ack_clk_counter.sv ***
// counts acknowledge clocks from the device above
`timescale 1ns/1ps
module ack_clk_counter (
   input wire logic core_clk,
   input wire logic arst_n,
   ack_clk_if.cnt link
);
   logic [3:0] cnt_q;
   logic good_q;
   logic bad_q;
   assign link.good = good_q;
   assign link.bad = bad_q;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= 4'h0;
         good_q <= 1'b0;
         bad_q <= 1'b0;
      end else begin
         good_q <= 1'b0;
         bad_q <= 1'b0;
         if (link.start) begin
            bad_q <= cnt_q != 4'h0; // see R16
            cnt_q <= 4'h0;
         end else if (link.clk_edge) begin
            if (cnt_q == stack_cmd_pkg::ENUM_ACK_CLOCKS - 4'h1) begin
               good_q <= 1'b1; // see R16
               cnt_q <= 4'h0;
            end else begin
               cnt_q <= cnt_q + 4'h1;
            end
         end
      end
   end
   AST_ACK_COUNT: assert property (@(posedge core_clk) disable iff (!arst_n)
      link.good |-> $past(cnt_q) == 4'h7) // see R16
      else $error("acknowledge accepted before eight clocks");
endmodule

// *** tb/upper_stack_model.sv ***
// far-side model: device above, converter and mux diagnostic
`timescale 1ns/1ps
module upper_stack_model (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic relay_up_q,
   input wire logic conv_start_q,
   input wire logic mux_test_q,
   input wire logic [3:0] ack_count,
   input wire logic rsp_en,
   output logic up_rsp_valid,
   output logic up_ack_clk,
   output logic conv_done,
   output logic mux_done
);
   logic was_conv;
   ////////////////////////////////////////////////////////////////////////
   // device above: acknowledge clocks, then optional reply
   initial begin
      up_rsp_valid = 1'b0;
      up_ack_clk = 1'b0;
      forever begin
         @(posedge core_clk);
         if (arst_n && relay_up_q) begin
            repeat (ack_count) begin
               #1 up_ack_clk = 1'b1;
               @(posedge core_clk);
               #1 up_ack_clk = 1'b0;
               @(posedge core_clk);
            end
            if (rsp_en) begin
               #1 up_rsp_valid = 1'b1;
               @(posedge core_clk);
               #1 up_rsp_valid = 1'b0;
            end
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // converter and mux diagnostic finish a few cycles after start
   initial begin
      conv_done = 1'b0;
      mux_done = 1'b0;
      forever begin
         @(posedge core_clk);
         if (arst_n && (conv_start_q || mux_test_q)) begin
            was_conv = conv_start_q;
            repeat (2) @(posedge core_clk);
            #1 conv_done = was_conv;
            mux_done = !was_conv;
            @(posedge core_clk);
            #1 conv_done = 1'b0;
            mux_done = 1'b0;
            repeat (2) @(posedge core_clk);
         end
      end
   end
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the stack command handler
`timescale 1ns/1ps
module testbench;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic is_master = 1'b0;
   logic [4:0] own_addr = 5'h02;
   logic [4:0] stack_size = 5'h05;
   logic cmd_valid = 1'b0;
   logic [7:0] cmd_code = 8'h00;
   logic [5:0] cmd_len = 6'h00;
   logic addr_match = 1'b0;
   logic crc_ok = 1'b1;
   logic reg_ok = 1'b1;
   logic is_write = 1'b0;
   logic lower_traffic = 1'b0;
   logic [3:0] ack_count = 4'h8;
   logic rsp_en = 1'b1;
   logic up_rsp_valid, up_ack_clk, conv_done, mux_done;
   logic scan_cont_q, balance_run_flag_q, sleep_q, enum_mode_q, is_top_q;
   logic conv_start_q, mux_test_q, relay_up_q, relay_down_q, rsp_valid_q;
   logic [5:0] conv_sel_q;
   logic [7:0] rsp_code_q;
   logic [4:0] rsp_pos_q;
   logic [5:0] ok_sel[9] = '{6'h00, 6'h01, 6'h0e, 6'h10, 6'h11, 6'h14,
      6'h17, 6'h18, 6'h19};
   logic [5:0] bad_sel[5] = '{6'h0f, 6'h15, 6'h16, 6'h1a, 6'h3f};
   int err_total = 0;
   int checks_done = 0;
   int cyc = 0;
   int rsp_n = 0, conv_n = 0, up_n = 0, down_n = 0, mux_n = 0, n, m;
   always #5 core_clk = ~core_clk;
   stack_command_handler #(.TIMEOUT_CYCLES(40)) u_dut (
      .core_clk(core_clk), .arst_n(arst_n), .is_master(is_master),
      .own_addr(own_addr), .stack_size(stack_size), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_len(cmd_len), .addr_match(addr_match),
      .crc_ok(crc_ok), .reg_ok(reg_ok), .is_write(is_write),
      .lower_traffic(lower_traffic), .up_rsp_valid(up_rsp_valid),
      .up_ack_clk(up_ack_clk), .conv_done(conv_done), .mux_done(mux_done),
      .scan_cont_q(scan_cont_q), .balance_run_flag_q(balance_run_flag_q),
      .sleep_q(sleep_q), .enum_mode_q(enum_mode_q), .is_top_q(is_top_q),
      .conv_start_q(conv_start_q), .conv_sel_q(conv_sel_q),
      .mux_test_q(mux_test_q), .relay_up_q(relay_up_q),
      .relay_down_q(relay_down_q), .rsp_valid_q(rsp_valid_q),
      .rsp_code_q(rsp_code_q), .rsp_pos_q(rsp_pos_q));
   upper_stack_model u_model (
      .core_clk(core_clk), .arst_n(arst_n), .relay_up_q(relay_up_q),
      .conv_start_q(conv_start_q), .mux_test_q(mux_test_q),
      .ack_count(ack_count), .rsp_en(rsp_en), .up_rsp_valid(up_rsp_valid),
      .up_ack_clk(up_ack_clk), .conv_done(conv_done), .mux_done(mux_done));
   ////////////////////////////////////////////////////////////////////////
   // pulse counters and run limit
   always @(posedge core_clk) begin
      cyc++;
      if (rsp_valid_q === 1'b1) rsp_n++;
      if (conv_start_q === 1'b1) conv_n++;
      if (relay_up_q === 1'b1) up_n++;
      if (relay_down_q === 1'b1) down_n++;
      if (mux_test_q === 1'b1) mux_n++;
      if (cyc == 6000) begin
         err_total++;
         test_done();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task test_done;
      if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk_val(input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   task chk_cnt(input int exp, input int got);
      chk_val(exp[7:0], got[7:0]);
   endtask
   task cmd(input logic [7:0] c, input logic [5:0] l, input logic am,
      input logic crc);
      @(posedge core_clk);
      #1 cmd_valid = 1'b1;
      cmd_code = c;
      cmd_len = l;
      addr_match = am;
      crc_ok = crc;
      @(posedge core_clk);
      #1 cmd_valid = 1'b0;
      repeat (70) @(posedge core_clk);
      #1;
   endtask
   task lower_pulse;
      @(posedge core_clk);
      #1 lower_traffic = 1'b1;
      @(posedge core_clk);
      #1 lower_traffic = 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge core_clk);
      #1 arst_n = 1'b1;
      chk_val(8'h00, {7'h00, scan_cont_q});
      cmd(stack_cmd_pkg::CMD_SCAN_CONT, 6'h00, 1'b1, 1'b1);
      chk_val(8'h01, {7'h00, scan_cont_q});
      n = rsp_n;
      cmd(stack_cmd_pkg::CMD_SCAN_INHIBIT, 6'h00, 1'b1, 1'b1);
      chk_val(8'h00, {7'h00, scan_cont_q});
      cmd(stack_cmd_pkg::CMD_SCAN_INHIBIT, 6'h00, 1'b1, 1'b1);
      chk_val(8'h00, {7'h00, scan_cont_q});
      chk_cnt(n, rsp_n);
      cmd(stack_cmd_pkg::CMD_BAL_ENABLE, 6'h00, 1'b1, 1'b1);
      chk_val(8'h01, {7'h00, balance_run_flag_q});
      cmd(stack_cmd_pkg::CMD_BAL_INHIBIT, 6'h00, 1'b1, 1'b1);
      chk_val(8'h00, {7'h00, balance_run_flag_q});
      cmd(stack_cmd_pkg::CMD_BAL_ENABLE, 6'h00, 1'b1, 1'b0);
      chk_val(stack_cmd_pkg::CMD_NAK, rsp_code_q);
      chk_val(8'h00, {7'h00, balance_run_flag_q});
      foreach (ok_sel[k]) begin
         n = conv_n;
         m = rsp_n;
         cmd(stack_cmd_pkg::CMD_MEASURE, ok_sel[k], 1'b1, 1'b1);
         chk_cnt(n + 1, conv_n);
         chk_cnt(m, rsp_n);
         chk_val({2'b00, ok_sel[k]}, {2'b00, conv_sel_q});
      end
      n = conv_n;
      cmd(stack_cmd_pkg::CMD_MEASURE, 6'h03, 1'b0, 1'b1);
      chk_cnt(n, conv_n);
      foreach (bad_sel[k]) begin
         cmd(stack_cmd_pkg::CMD_ACK, 6'h00, 1'b1, 1'b1);
         cmd(stack_cmd_pkg::CMD_MEASURE, bad_sel[k], 1'b1, 1'b1);
         chk_cnt(n, conv_n);
         chk_val(stack_cmd_pkg::CMD_NAK, rsp_code_q);
      end
      cmd(stack_cmd_pkg::CMD_MUX_TEST, 6'h00, 1'b1, 1'b1);
      chk_val(8'h01, {7'h00, mux_n != 0});
      chk_val(8'h00, {7'h00, mux_test_q});
      n = up_n;
      m = down_n;
      cmd(stack_cmd_pkg::CMD_ENUMERATE, 6'h00, 1'b0, 1'b1);
      chk_cnt(n + 1, up_n);
      chk_cnt(m + 1, down_n);
      chk_val(8'h01, {7'h00, enum_mode_q});
      lower_pulse();
      chk_val(8'h00, {7'h00, enum_mode_q});
      ack_count = 4'h7;
      rsp_en = 1'b0;
      cmd(stack_cmd_pkg::CMD_ENUMERATE, 6'h00, 1'b0, 1'b1);
      chk_val(stack_cmd_pkg::CMD_ENUMERATE, rsp_code_q);
      chk_val({3'h0, own_addr}, {3'h0, rsp_pos_q});
      ack_count = 4'h8;
      cmd(stack_cmd_pkg::CMD_ENUMERATE, 6'h00, 1'b0, 1'b1);
      chk_val(stack_cmd_pkg::CMD_COMMS_FAIL, rsp_code_q);
      n = rsp_n;
      m = up_n;
      cmd(stack_cmd_pkg::CMD_ENUMERATE, 6'h00, 1'b0, 1'b0);
      chk_cnt(n, rsp_n);
      chk_cnt(m, up_n);
      is_master = 1'b1;
      cmd(stack_cmd_pkg::CMD_ENUMERATE, 6'h00, 1'b0, 1'b0);
      chk_val(stack_cmd_pkg::CMD_NAK, rsp_code_q);
      is_master = 1'b0;
      ack_count = 4'h0;
      rsp_en = 1'b1;
      m = down_n;
      cmd(stack_cmd_pkg::CMD_ACK, 6'h00, 1'b0, 1'b1);
      chk_cnt(m + 1, down_n);
      rsp_en = 1'b0;
      cmd(stack_cmd_pkg::CMD_ACK, 6'h00, 1'b0, 1'b1);
      chk_val(stack_cmd_pkg::CMD_COMMS_FAIL, rsp_code_q);
      own_addr = 5'h05;
      cmd(stack_cmd_pkg::CMD_ENUMERATE, 6'h00, 1'b0, 1'b1);
      chk_val(stack_cmd_pkg::CMD_ENUMERATE, rsp_code_q);
      chk_val(8'h05, {3'h0, rsp_pos_q});
      chk_val(8'h01, {7'h00, is_top_q});
      lower_pulse();
      cmd(stack_cmd_pkg::CMD_ACK, 6'h00, 1'b1, 1'b1);
      chk_val(stack_cmd_pkg::CMD_ACK, rsp_code_q);
      reg_ok = 1'b0;
      cmd(8'h01, 6'h00, 1'b1, 1'b1);
      chk_val(stack_cmd_pkg::CMD_NAK, rsp_code_q);
      reg_ok = 1'b1;
      is_write = 1'b1;
      cmd(8'h01, 6'h00, 1'b1, 1'b1);
      chk_val(stack_cmd_pkg::CMD_ACK, rsp_code_q);
      is_write = 1'b0;
      cmd(stack_cmd_pkg::CMD_SLEEP, 6'h00, 1'b1, 1'b1);
      chk_val(8'h01, {7'h00, sleep_q});
      test_done();
   end
endmodule
